// [logic/fwg_cpu.sv]
/*
 CPU end: turns a plain software port into special-register and
 external-move cycles on the interface. Holds moves while stalled.
 Assumes the device answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module fwg_cpu (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  fwg_if.cpu BUS,
  input wire logic [1:0] SEL,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic BUSY
);
  import fwg_pkg::*;
  // SEL: 00 special register, 01 sixteen-bit move, 10 eight-bit move
  logic rd_sfr;
  logic rd_mv;

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS.sfr_addr <= 8'h00;
      BUS.sfr_wdata <= 8'h00;
      BUS.sfr_wr <= 1'b0;
      BUS.sfr_rd <= 1'b0;
      BUS.mv_addr <= 16'h0000;
      BUS.mv_short <= 1'b0;
      BUS.mv_wdata <= 8'h00;
      BUS.mv_wr <= 1'b0;
      BUS.mv_rd <= 1'b0;
    end else if (!BUS.stall) begin
      BUS.sfr_addr <= ADDR[7:0];
      BUS.sfr_wdata <= WDATA;
      BUS.sfr_wr <= WR && SEL == 2'b00;
      BUS.sfr_rd <= RD && SEL == 2'b00;
      BUS.mv_addr <= ADDR;
      BUS.mv_short <= SEL == 2'b10;
      BUS.mv_wdata <= WDATA;
      BUS.mv_wr <= WR && SEL != 2'b00;
      BUS.mv_rd <= RD && SEL != 2'b00;
    end else begin
      // Strobes drop while stalled so a held request is not taken twice
      BUS.sfr_wr <= 1'b0;
      BUS.sfr_rd <= 1'b0;
      BUS.mv_wr <= 1'b0;
      BUS.mv_rd <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_sfr <= 1'b0;
      rd_mv <= 1'b0;
      RDATA <= 8'h00;
      BUSY <= 1'b0;
    end else begin
      rd_sfr <= BUS.sfr_rd;
      rd_mv <= BUS.mv_rd;
      RDATA <= rd_sfr ? BUS.sfr_rdata : (rd_mv ? BUS.mv_rdata : 8'h00);
      BUSY <= BUS.stall;
    end
  end
endmodule : fwg_cpu
`default_nettype wire

// [logic/fwg_gate.sv]
/*
 Device end: program-store control, unlock key machine, read scale,
 data RAM with page select, and a flash array model with page erase.
 Assumes the CPU end makes no new request while stall is high.
*/
// Added by the designer: the address-and-strobe port.
// Functional notes
// R1 - Control register upper six bits read zero
// R2 - Write enable routes moves to flash program
// R3 - Both enables make writes erase page
// R4 - Writing disabled means moves hit RAM
// R5 - Unlock needs first key then second key
// R6 - Relock after each finished flash operation
// R7 - Bad key or locked attempt kills until reset
// R8 - Key read shows lock state low bits
// R9 - One-shot bit selects sense amp pulse mode
// R10 - Scale register low seven bits read zero
// R11 - Sixteen-bit moves ignore upper seven bits
// R12 - Eight-bit moves take page from register
// R13 - Page register only bit zero kept
// R14 - Software erases before programming
// R15 - Software uses internal clock while programming
// R16 - Erase clears whole aligned page
// R17 - Stall CPU until operation completes, then relock
`timescale 1ns/1ps
`default_nettype none
module fwg_gate (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  fwg_if.dev BUS,
  output logic SENSE_ONE_SHOT,
  output logic [1:0] KEY_STATE
);
  import fwg_pkg::*;

  typedef enum logic [3:0] {
    ST_LOCKED = 4'b0001,
    ST_FIRST = 4'b0010,
    ST_OPEN = 4'b0100,
    ST_DEAD = 4'b1000
  } fwg_key_t;

  fwg_key_t key_st;
  fwg_key_t next_key_st;
  logic write_en;
  logic erase_en;
  logic one_shot;
  logic page_bit;
  logic [7:0] ram [0:(1<<RAM_ADDR_W)-1];
  logic [7:0] flash [0:(1<<FLASH_ADDR_W)-1];
  logic busy;
  logic [$clog2(PROG_CYCLES+1)-1:0] busy_cnt;
  logic op_erase;
  logic [FLASH_ADDR_W-1:0] op_addr;
  logic [7:0] op_data;
  logic [RAM_ADDR_W-1:0] ram_addr;
  logic flash_try;

  function automatic logic [1:0] key_code(input fwg_key_t s);
    case (s)
      ST_FIRST: key_code = KS_FIRST;
      ST_OPEN: key_code = KS_OPEN;
      ST_DEAD: key_code = KS_DEAD;
      default: key_code = KS_LOCKED;
    endcase
  endfunction : key_code

  // Eight-bit moves use the page bit as high address bit
  assign ram_addr = BUS.mv_short ? {page_bit, BUS.mv_addr[7:0]} // R12
                                 : BUS.mv_addr[RAM_ADDR_W-1:0]; // R11
  assign flash_try = BUS.mv_wr && write_en && !busy; // R2

  always_comb begin
    next_key_st = key_st;
    case (key_st)
      ST_LOCKED: begin
        if (BUS.sfr_wr && BUS.sfr_addr == ADDR_UNLOCK_KEY) begin
          next_key_st = (BUS.sfr_wdata == KEY_FIRST) ? ST_FIRST
                                                    : ST_DEAD; // R7
        end else if (flash_try) begin
          next_key_st = ST_DEAD; // R7
        end
      end
      ST_FIRST: begin
        if (BUS.sfr_wr && BUS.sfr_addr == ADDR_UNLOCK_KEY) begin
          next_key_st = (BUS.sfr_wdata == KEY_SECOND) ? ST_OPEN
                                                     : ST_DEAD; // R5
        end else if (flash_try) begin
          next_key_st = ST_DEAD; // R7
        end
      end
      ST_OPEN: begin
        if (BUS.sfr_wr && BUS.sfr_addr == ADDR_UNLOCK_KEY) begin
          next_key_st = ST_DEAD; // R7
        end else if (busy && busy_cnt == 0) begin
          next_key_st = ST_LOCKED; // R6 R17
        end
      end
      ST_DEAD: next_key_st = ST_DEAD;
      default: next_key_st = ST_DEAD;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_st <= ST_LOCKED;
    end else begin
      key_st <= next_key_st;
    end
  end

  // Control registers; unused bits are simply not stored
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      write_en <= RST_PROG_CTRL[BIT_WRITE_EN];
      erase_en <= RST_PROG_CTRL[BIT_ERASE_EN];
      one_shot <= RST_READ_SCALE[BIT_ONE_SHOT];
      page_bit <= RST_PAGE_SEL[BIT_PAGE];
    end else if (BUS.sfr_wr) begin
      case (BUS.sfr_addr)
        ADDR_PROG_CTRL: begin
          write_en <= BUS.sfr_wdata[BIT_WRITE_EN]; // R1
          erase_en <= BUS.sfr_wdata[BIT_ERASE_EN];
        end
        ADDR_READ_SCALE: one_shot <= BUS.sfr_wdata[BIT_ONE_SHOT]; // R10
        ADDR_PAGE_SEL: page_bit <= BUS.sfr_wdata[BIT_PAGE]; // R13
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS.sfr_rdata <= 8'h00;
    end else if (BUS.sfr_rd) begin
      case (BUS.sfr_addr)
        ADDR_PROG_CTRL: BUS.sfr_rdata <= {6'b00_0000, erase_en, write_en}; // R1
        ADDR_READ_SCALE: BUS.sfr_rdata <= {one_shot, 7'h00}; // R10
        ADDR_PAGE_SEL: BUS.sfr_rdata <= {7'h00, page_bit}; // R13
        ADDR_UNLOCK_KEY: BUS.sfr_rdata <= {6'b00_0000, key_code(key_st)}; // R8
        default: BUS.sfr_rdata <= 8'h00;
      endcase
    end else begin
      BUS.sfr_rdata <= 8'h00;
    end
  end

  // Flash operation sequencer; holds the CPU while programming
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy <= 1'b0;
      busy_cnt <= '0;
      op_erase <= 1'b0;
      op_addr <= '0;
      op_data <= 8'h00;
    end else if (busy) begin
      if (busy_cnt == 0) begin
        busy <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt - 1'b1;
      end
    end else if (flash_try && key_st == ST_OPEN) begin
      busy <= 1'b1; // R17
      busy_cnt <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES - 1);
      op_erase <= erase_en; // R3
      op_addr <= BUS.mv_addr[FLASH_ADDR_W-1:0];
      op_data <= BUS.mv_wdata;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS.stall <= 1'b0;
    end else begin
      BUS.stall <= (flash_try && key_st == ST_OPEN)
                   || (busy && busy_cnt != 0); // R17
    end
  end

  // Array writes at completion; erase walks the aligned page
  always_ff @(posedge REF_CLK) begin
    if (busy && busy_cnt == 0) begin
      if (op_erase) begin
        for (int i = 0; i < (1 << FLASH_PAGE_W); i++) begin
          flash[{op_addr[FLASH_ADDR_W-1:FLASH_PAGE_W],
                 FLASH_PAGE_W'(i)}] <= ERASED_BYTE; // R16
        end
      end else begin
        flash[op_addr] <= flash[op_addr] & op_data; // R2
      end
    end
    if (BUS.mv_wr && !write_en) begin
      ram[ram_addr] <= BUS.mv_wdata; // R4
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS.mv_rdata <= 8'h00;
    end else if (BUS.mv_rd) begin
      BUS.mv_rdata <= ram[ram_addr]; // R4
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SENSE_ONE_SHOT <= RST_READ_SCALE[BIT_ONE_SHOT];
      KEY_STATE <= KS_LOCKED;
    end else begin
      SENSE_ONE_SHOT <= one_shot; // R9
      KEY_STATE <= key_code(next_key_st);
    end
  end
endmodule : fwg_gate
`default_nettype wire

// [logic/fwg_if.sv]
/*
 Interface joining the CPU end and the flash gate end.
 Assumes both ends run on the same clock; the bench supplies it.
*/
`timescale 1ns/1ps
`default_nettype none
interface fwg_if;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic sfr_wr;
  logic sfr_rd;
  logic [7:0] sfr_rdata;
  logic [15:0] mv_addr;
  logic mv_short;
  logic [7:0] mv_wdata;
  logic mv_wr;
  logic mv_rd;
  logic [7:0] mv_rdata;
  logic stall;
  modport cpu (output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mv_addr,
    mv_short, mv_wdata, mv_wr, mv_rd, input sfr_rdata, mv_rdata, stall);
  modport dev (input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mv_addr,
    mv_short, mv_wdata, mv_wr, mv_rd, output sfr_rdata, mv_rdata, stall);
endinterface : fwg_if
`default_nettype wire

// [logic/fwg_pkg.sv]
/*
 Package for the flash write/erase gate and data RAM paging block.
 Assumes one system clock and an active-low asynchronous reset.
*/
package fwg_pkg;
  localparam logic [7:0] ADDR_PROG_CTRL = 8'h8F;
  localparam logic [7:0] ADDR_PAGE_SEL = 8'hAA;
  localparam logic [7:0] ADDR_READ_SCALE = 8'hB6;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'hB7;
  localparam logic [7:0] RST_PROG_CTRL = 8'h00;
  localparam logic [7:0] RST_PAGE_SEL = 8'h00;
  localparam logic [7:0] RST_READ_SCALE = 8'h80;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam int BIT_WRITE_EN = 0;
  localparam int BIT_ERASE_EN = 1;
  localparam int BIT_ONE_SHOT = 7;
  localparam int BIT_PAGE = 0;
  localparam int RAM_ADDR_W = 9;
  localparam int FLASH_ADDR_W = 13;
  localparam int FLASH_PAGE_W = 9;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [1:0] KS_LOCKED = 2'b00;
  localparam logic [1:0] KS_FIRST = 2'b01;
  localparam logic [1:0] KS_OPEN = 2'b10;
  localparam logic [1:0] KS_DEAD = 2'b11;
  localparam int PROG_CYCLES = 4;
endpackage : fwg_pkg

// [test/fwg_properties.sv]
/*
 Checker on the signals between the CPU end and the flash gate end.
 Assumes one clock and the active-low asynchronous reset of the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module fwg_properties (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic mv_wr,
  input wire logic stall
);
  import fwg_pkg::*;
  logic touched;
  logic dead;
  logic key_wr;
  assign key_wr = sfr_wr && sfr_addr == ADDR_UNLOCK_KEY;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Any key write ends the fresh state; a bad key value kills
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      touched <= 1'b0;
      dead <= 1'b0;
    end else if (key_wr) begin
      touched <= 1'b1;
      if (sfr_wdata != KEY_FIRST && sfr_wdata != KEY_SECOND) begin
        dead <= 1'b1;
      end
    end
  end
  sequence s_keyrd;
    sfr_rd && sfr_addr == ADDR_UNLOCK_KEY;
  endsequence
  sequence s_unlock;
    key_wr && sfr_wdata == KEY_FIRST && !touched ##[1:3]
      key_wr && sfr_wdata == KEY_SECOND;
  endsequence
  property p_unlock;
    s_unlock ##[1:4] s_keyrd |=> sfr_rdata[1:0] == KS_OPEN;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("key read after unlock not open");
  property p_dead;
    dead ##0 s_keyrd |=> sfr_rdata[1:0] == KS_DEAD;
  endproperty
  a_dead: assert property (p_dead)
    else $error("key read after bad key not disabled");
  property p_ctrl;
    sfr_rd && sfr_addr == ADDR_PROG_CTRL |=> sfr_rdata[7:2] == 6'h00;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control upper bits not zero");
  property p_scale;
    sfr_rd && sfr_addr == ADDR_READ_SCALE |=> sfr_rdata[6:0] == 7'h00;
  endproperty
  a_scale: assert property (p_scale)
    else $error("scale low bits not zero");
  property p_page;
    sfr_rd && sfr_addr == ADDR_PAGE_SEL |=> sfr_rdata[7:1] == 7'h00;
  endproperty
  a_page: assert property (p_page)
    else $error("page select upper bits not zero");
  property p_rd_idle;
    !$past(sfr_rd) |-> sfr_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside answer");
  property p_stall_cause;
    $rose(stall) |-> $past(mv_wr);
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without a move write");
  property p_stall_end;
    $rose(stall) |-> stall [*4] ##1 !stall;
  endproperty
  a_stall_end: assert property (p_stall_end)
    else $error("stall too long");
endmodule : fwg_properties
`default_nettype wire

// [test/test_flash_write_erase_gate_on_chip_data_ram_paging.sv]
/*
 Bench driving the software port of the CPU end, joined to the gate.
 Assumes read data three cycles after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flash_write_erase_gate_on_chip_data_ram_paging;
  import fwg_pkg::*;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic [1:0] sel = 0;
  logic [15:0] addr = 0;
  logic [7:0] wdata = 0;
  logic wr = 0;
  logic rd = 0;
  logic [7:0] rdata;
  logic busy;
  logic sense;
  logic [1:0] key_st;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  fwg_if bus ();
  fwg_gate i_fwg_gate (.REF_CLK(ref_clk), .ARST_N(arst_n), .BUS(bus.dev),
    .SENSE_ONE_SHOT(sense), .KEY_STATE(key_st));
  fwg_cpu i_fwg_cpu (.REF_CLK(ref_clk), .ARST_N(arst_n), .BUS(bus.cpu),
    .SEL(sel), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .BUSY(busy));
  fwg_properties i_fwg_properties (.REF_CLK(ref_clk), .ARST_N(arst_n),
    .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata),
    .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_rdata(bus.sfr_rdata),
    .mv_wr(bus.mv_wr), .stall(bus.stall));
  always #4 ref_clk = ~ref_clk;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wo(input logic [1:0] s, input logic [15:0] a,
    input logic [7:0] d);
    @(posedge ref_clk);
    sel <= s;
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wo
  task automatic ro(input logic [1:0] s, input logic [15:0] a,
    input logic [7:0] e, input string n);
    @(posedge ref_clk);
    sel <= s;
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(n, e, rdata);
  endtask : ro
  // Flash operation with the key pair, then wait out the stall
  task automatic t_flash(input logic [15:0] a, input logic [7:0] d,
    input logic [12:0] ca, input logic [7:0] ce);
    wo(2'b00, 16'h00B7, KEY_FIRST);
    wo(2'b00, 16'h00B7, KEY_SECOND);
    ro(2'b00, 16'h00B7, 8'h02, "key open");
    chk("key out", 8'h02, {6'h00, key_st});
    // The one bench clock runs on unchanged through the operation
    wo(2'b01, a, d);
    repeat (2) @(posedge ref_clk);
    #1 chk("busy on", 8'h01, {7'h00, busy});
    repeat (4) @(posedge ref_clk);
    #1 chk("busy off", 8'h00, {7'h00, busy});
    ro(2'b00, 16'h00B7, 8'h00, "key relock");
    chk("flash byte", ce, i_fwg_gate.flash[ca]);
  endtask : t_flash
  task automatic t_ram;
    wo(2'b01, 16'h0005, 8'h3C);
    ro(2'b01, 16'hFE05, 8'h3C, "ram alias");
    wo(2'b00, 16'h00AA, 8'hFF);
    ro(2'b00, 16'h00AA, 8'h01, "page sel");
    wo(2'b10, 16'h0007, 8'h5A);
    ro(2'b01, 16'h0107, 8'h5A, "paged move");
  endtask : t_ram
  task automatic t_scale;
    ro(2'b00, 16'h00B6, RST_READ_SCALE, "scale rst");
    chk("one shot", 8'h01, {7'h00, sense});
    wo(2'b00, 16'h00B6, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 chk("one shot", 8'h00, {7'h00, sense});
  endtask : t_scale
  task automatic t_lock;
    wo(2'b00, 16'h008F, 8'h01);
    wo(2'b01, 16'h0020, 8'h55);
    repeat (12) @(posedge ref_clk);
    chk("flash kept", ERASED_BYTE, i_fwg_gate.flash[13'h0020]);
    wo(2'b00, 16'h00B7, 8'h00);
    wo(2'b00, 16'h00B7, KEY_FIRST);
    wo(2'b00, 16'h00B7, KEY_SECOND);
    ro(2'b00, 16'h00B7, 8'h03, "key dead");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    ro(2'b00, 16'h00B7, 8'h00, "key reset");
    ro(2'b00, 16'h008F, RST_PROG_CTRL, "ctrl reset");
    wo(2'b00, 16'h00B7, KEY_SECOND);
    ro(2'b00, 16'h00B7, 8'h03, "key order");
  endtask : t_lock
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    ro(2'b00, 16'h00AA, RST_PAGE_SEL, "page rst");
    wo(2'b01, 16'h0010, 8'h11);
    wo(2'b00, 16'h008F, 8'hFF);
    ro(2'b00, 16'h008F, 8'h03, "ctrl bits");
    t_flash(16'h0123, 8'h00, 13'h0010, ERASED_BYTE);
    chk("erase top", ERASED_BYTE, i_fwg_gate.flash[13'h01FF]);
    wo(2'b00, 16'h008F, 8'h01);
    t_flash(16'h0010, 8'h22, 13'h0010, 8'h22);
    wo(2'b00, 16'h008F, 8'h00);
    ro(2'b01, 16'h0010, 8'h11, "ram kept");
    t_ram();
    t_scale();
    t_lock();
    print_verdict();
  end
endmodule : test_flash_write_erase_gate_on_chip_data_ram_paging
`default_nettype wire
